// [tmu_opt.sv]
/*
 * Option-byte driven temporary read-out unprotection and bootloader forcing.
 * Holds the stored key bytes and access failure counter without copies, and the control byte and
 * bootloader enable byte with their complement copies; compares presented
 * keys, counts failures, requests mass erase and forces the bootloader.
 * Assumes option writes and key attempts are synchronous single-cycle strobes
 * from the option programming path, and that memory erase is done elsewhere.
 */
// Overview of operation
// (RL1) Programmer must never store a key byte of all zeros or all ones.
// (RL2) Failure counter accepts a written value only while feature control field reads 0101.
// (RL3) While enabled, every key attempt with wrong values increments the failure counter; the code stops counting once it reaches eight.
// (RL4) Counter reaching eight requests erase of program flash and data EEPROM.
// (RL5) Boot byte 0x55 with complement 0xAA forces the bootloader to start.
// (RL6) Option bytes keep an inverted copy, except protection byte and bytes 8 to 16.
// (RL7) Protection lifts only when all presented key bytes match the stored key bytes.

`timescale 1ns/1ps

module tmu_opt (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Option byte write port
	input  wire logic        opt_we,
	input  wire logic [4:0]  opt_index,
	input  wire logic [7:0]  opt_wdata,
	// Option byte read port
	input  wire logic [4:0]  opt_rindex,
	input  wire logic        opt_rcompl,
	output logic      [7:0]  opt_rdata,
	// Key attempt from programmer or application
	input  wire logic        key_valid,
	input  wire logic [31:0] key_data,
	// Results
	output logic             readout_unlocked,
	output logic             mass_erase,
	output logic             boot_loader_force,
	output logic             key_cfg_bad,
	output logic             temp_unprotect_en
);
	import tmu_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] unprotect_key [KEY_COUNT];
	logic [7:0] unprotect_ctrl_byte;
	logic [7:0] unprotect_ctrl_byte_n;
	logic [7:0] unprotect_fail_count;
	logic [7:0] boot_loader_enable;
	logic [7:0] boot_loader_enable_n;

	// Index belongs to the range kept without complement copy
	function automatic logic no_dup(input logic [4:0] idx);
		no_dup = (idx >= OPT_IDX_NODUP_LO) && (idx <= OPT_IDX_NODUP_HI);
	endfunction : no_dup

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire  logic [KEY_COUNT-1:0] key_hit;
	wire  logic [KEY_COUNT-1:0] key_we;
	wire  logic [KEY_COUNT-1:0] key_odd;
	wire  logic           tu_enabled;
	wire  logic           key_ok;
	wire  logic           key_bad;
	wire  logic           fail_we;
	wire  logic           at_limit;
	wire  logic [7:0]     next_fail_count;

	// Per-key compare, write decode and value check
	genvar gi;
	generate
		for (gi = 0; gi < KEY_COUNT; gi++) begin : g_key
			assign key_hit[gi] = (key_data[8*gi +: 8] == unprotect_key[gi]);
			assign key_we[gi]  = opt_we && (opt_index == OPT_IDX_KEY5 + 5'(gi));
			assign key_odd[gi] = (unprotect_key[gi] == KEY_ALL_ZERO) || (unprotect_key[gi] == KEY_ALL_ONE);
		end
	endgenerate

	// Feature state and attempt outcome
	assign tu_enabled      = unprotect_ctrl_byte[CTRL_FIELD_LSB +: CTRL_FIELD_W] != CTRL_DISABLE;
	assign key_ok          = &key_hit;                                            // RL7
	assign at_limit        = unprotect_fail_count >= FAIL_LIMIT;
	assign key_bad         = key_valid && tu_enabled && !key_ok && !at_limit;     // RL3
	assign fail_we         = opt_we && (opt_index == OPT_IDX_FAIL) && !tu_enabled; // RL2
	assign next_fail_count = unprotect_fail_count + FAIL_STEP;

	// ----------------------------------------------------------------
	// Key bytes
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < KEY_COUNT; gi++) begin : g_key_reg
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					unprotect_key[gi] <= OPT_RESET;
				end else if (key_we[gi]) begin
					unprotect_key[gi] <= opt_wdata;
				end
			end
		end
	endgenerate

	// Control and bootloader bytes with inverted copies
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			unprotect_ctrl_byte   <= OPT_RESET;
			unprotect_ctrl_byte_n <= OPT_COMPL_RESET;
			boot_loader_enable    <= OPT_RESET;
			boot_loader_enable_n  <= OPT_COMPL_RESET;
		end else if (opt_we) begin
			if (opt_index == OPT_IDX_CTRL) begin
				unprotect_ctrl_byte   <= opt_wdata;
				unprotect_ctrl_byte_n <= ~opt_wdata; // RL6
			end else if (opt_index == OPT_IDX_BOOT) begin
				boot_loader_enable    <= opt_wdata;
				boot_loader_enable_n  <= ~opt_wdata; // RL6
			end
		end
	end

	// Failure counter: set only while disabled, counts only while enabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			unprotect_fail_count <= OPT_RESET;
		end else if (fail_we) begin
			unprotect_fail_count <= opt_wdata; // RL2
		end else if (key_bad) begin
			unprotect_fail_count <= next_fail_count; // RL3
		end
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------
	// Unlock is sticky until reset; erase pulses once on reaching the limit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readout_unlocked <= 1'b0;
			mass_erase       <= 1'b0;
		end else begin
			if (key_valid && tu_enabled && key_ok && !at_limit) begin
				readout_unlocked <= 1'b1; // RL7
			end
			mass_erase <= key_bad && (next_fail_count == FAIL_LIMIT); // RL4
		end
	end

	// Bootloader force, key sanity flag and feature state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_loader_force <= 1'b0;
			key_cfg_bad       <= 1'b0;
			temp_unprotect_en <= 1'b0;
		end else begin
			boot_loader_force <= (boot_loader_enable == BOOT_ON) && (boot_loader_enable_n == BOOT_ON_COMPL); // RL5
			key_cfg_bad       <= |key_odd; // RL1
			temp_unprotect_en <= tu_enabled;
		end
	end

	// Read mux: complement copy or true byte
	wire logic [7:0] rd_true;
	wire logic [7:0] rd_compl;
	assign rd_true = (opt_rindex == OPT_IDX_CTRL) ? unprotect_ctrl_byte :
		(opt_rindex == OPT_IDX_KEY5) ? unprotect_key[0] :
		(opt_rindex == OPT_IDX_KEY6) ? unprotect_key[1] :
		(opt_rindex == OPT_IDX_KEY7) ? unprotect_key[2] :
		(opt_rindex == OPT_IDX_KEY8) ? unprotect_key[3] :
		(opt_rindex == OPT_IDX_FAIL) ? unprotect_fail_count :
		(opt_rindex == OPT_IDX_BOOT) ? boot_loader_enable : OPT_RESET;
	assign rd_compl = (opt_rindex == OPT_IDX_CTRL) ? unprotect_ctrl_byte_n :
		(opt_rindex == OPT_IDX_BOOT) ? boot_loader_enable_n : OPT_RESET;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opt_rdata <= OPT_RESET;
		end else begin
			opt_rdata <= (opt_rcompl && !no_dup(opt_rindex)) ? rd_compl : rd_true; // RL6
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_fail_locked;
		@(posedge clk) disable iff (!arst_n)
		(opt_we && opt_index == OPT_IDX_FAIL && tu_enabled && !key_valid) |=> $stable(unprotect_fail_count);
	endproperty
	a_fail_locked: assert property (p_fail_locked) else $error("counter written while enabled"); // RL2

	property p_fail_inc;
		@(posedge clk) disable iff (!arst_n)
		(key_valid && tu_enabled && !(&key_hit) && unprotect_fail_count < FAIL_LIMIT)
			|=> unprotect_fail_count == $past(unprotect_fail_count) + FAIL_STEP;
	endproperty
	a_fail_inc: assert property (p_fail_inc) else $error("wrong key did not increment counter"); // RL3

	property p_erase;
		@(posedge clk) disable iff (!arst_n)
		$rose(unprotect_fail_count == FAIL_LIMIT) && $past(tu_enabled) |-> mass_erase;
	endproperty
	a_erase: assert property (p_erase) else $error("no erase at failure limit"); // RL4

	property p_boot;
		@(posedge clk) disable iff (!arst_n)
		##1 boot_loader_force == ($past(boot_loader_enable) == BOOT_ON && $past(boot_loader_enable_n) == BOOT_ON_COMPL);
	endproperty
	a_boot: assert property (p_boot) else $error("bootloader force mismatch"); // RL5

	property p_compl;
		@(posedge clk) disable iff (!arst_n)
		(opt_we && opt_index == OPT_IDX_CTRL)
			|=> (unprotect_ctrl_byte == $past(opt_wdata)) && (unprotect_ctrl_byte_n == ~$past(opt_wdata));
	endproperty
	a_compl: assert property (p_compl) else $error("control copy not inverted"); // RL6

	property p_unlock;
		@(posedge clk) disable iff (!arst_n)
		$rose(readout_unlocked) |-> $past(key_valid) && $past(&key_hit) && $past(tu_enabled);
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock without matching key"); // RL7

endmodule : tmu_opt

// [tmu_pkg.sv]
/*
 * Constants for the temporary read-out unprotection and bootloader option logic:
 * option byte numbers, field positions, patterns, reset values and limits.
 * Assumes it is compiled before any file that imports it.
 */

package tmu_pkg;

	// ----------------------------------------------------------------
	// Option byte numbers, used as the index on the option port
	// ----------------------------------------------------------------
	localparam logic [4:0] OPT_IDX_CTRL  = 5'h06; // Unprotect control byte
	localparam logic [4:0] OPT_IDX_KEY5  = 5'h0C; // First stored key byte
	localparam logic [4:0] OPT_IDX_KEY6  = 5'h0D;
	localparam logic [4:0] OPT_IDX_KEY7  = 5'h0E;
	localparam logic [4:0] OPT_IDX_KEY8  = 5'h0F;
	localparam logic [4:0] OPT_IDX_FAIL  = 5'h10; // Access failure counter
	localparam logic [4:0] OPT_IDX_BOOT  = 5'h11; // Bootloader enable byte
	localparam logic [4:0] OPT_IDX_NODUP_LO = 5'h08; // Bytes without complement copy
	localparam logic [4:0] OPT_IDX_NODUP_HI = 5'h10;

	// ----------------------------------------------------------------
	// Fields, patterns and limits
	// ----------------------------------------------------------------
	localparam int         KEY_COUNT        = 4;
	localparam int         CTRL_FIELD_LSB   = 0;
	localparam int         CTRL_FIELD_W     = 4;
	localparam logic [3:0] CTRL_DISABLE     = 4'h5;   // Pattern 0101 switches feature off
	localparam logic [7:0] FAIL_LIMIT       = 8'h08;  // Mass erase at this count
	localparam logic [7:0] FAIL_STEP        = 8'h01;
	localparam logic [7:0] BOOT_ON          = 8'h55;
	localparam logic [7:0] BOOT_ON_COMPL    = 8'hAA;
	localparam logic [7:0] KEY_ALL_ZERO     = 8'h00;
	localparam logic [7:0] KEY_ALL_ONE      = 8'hFF;

	// ----------------------------------------------------------------
	// Reset values (factory defaults)
	// ----------------------------------------------------------------
	localparam logic [7:0] OPT_RESET        = 8'h00;
	localparam logic [7:0] OPT_COMPL_RESET  = 8'hFF;

endpackage : tmu_pkg

// [tmu_prog_model.sv]
/*
 * Programmer model: writes option bytes and presents unprotection keys.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps

module tmu_prog_model (
	// Clock
	input  wire logic        clk,
	// Option write and key attempt
	output logic             opt_we,
	output logic      [4:0]  opt_index,
	output logic      [7:0]  opt_wdata,
	output logic             key_valid,
	output logic      [31:0] key_data
);
	import tmu_pkg::*;

	// Idle levels at time zero
	initial begin
		opt_we    = 1'b0;
		opt_index = 5'h00;
		opt_wdata = 8'h00;
		key_valid = 1'b0;
		key_data  = 32'h0;
	end

	// One write strobe; released data shows inverted value
	task automatic wr_opt(input logic [4:0] idx, input logic [7:0] val, input int gap);
		opt_index = idx;
		opt_wdata = val;
		opt_we    = 1'b1;
		@(posedge clk);
		#1;
		opt_we    = 1'b0;
		opt_wdata = ~val;
		repeat (gap) begin
			@(posedge clk);
			#1;
		end
	endtask : wr_opt

	// Stores four key bytes, never 0x00 or 0xFF by caller choice
	task automatic prog_keys(input logic [31:0] k);
		wr_opt(OPT_IDX_KEY5, k[7:0], 1);
		wr_opt(OPT_IDX_KEY6, k[15:8], 1);
		wr_opt(OPT_IDX_KEY7, k[23:16], 1);
		wr_opt(OPT_IDX_KEY8, k[31:24], 0);
	endtask : prog_keys

	// One key attempt, then gap idle cycles
	task automatic try_key(input logic [31:0] k, input int gap);
		key_data  = k;
		key_valid = 1'b1;
		@(posedge clk);
		#1;
		key_valid = 1'b0;
		key_data  = ~k;
		repeat (gap) begin
			@(posedge clk);
			#1;
		end
	endtask : try_key
endmodule : tmu_prog_model

// [testbench.sv]
/*
 * Self-checking bench for the unprotection option logic.
 * Assumes tmu_pkg, tmu_opt and tmu_prog_model are compiled first.
 */
`timescale 1ns/1ps

module testbench;
	import tmu_pkg::*;
	localparam logic [31:0] KEY_GOOD = 32'hD4C3B2A1;
	logic        clk, arst_n, opt_we, key_valid, opt_rcompl;
	logic [4:0]  opt_index, opt_rindex;
	logic [7:0]  opt_wdata, opt_rdata;
	logic [31:0] key_data;
	logic        unl, ers, boot, kbad, en;
	int          error_cnt, comparisons, erase_cnt;

	tmu_prog_model u_prog (.clk(clk), .opt_we(opt_we), .opt_index(opt_index), .opt_wdata(opt_wdata),
		.key_valid(key_valid), .key_data(key_data));
	tmu_opt u_dut (.clk(clk), .arst_n(arst_n), .opt_we(opt_we), .opt_index(opt_index),
		.opt_wdata(opt_wdata), .opt_rindex(opt_rindex), .opt_rcompl(opt_rcompl), .opt_rdata(opt_rdata),
		.key_valid(key_valid), .key_data(key_data), .readout_unlocked(unl), .mass_erase(ers),
		.boot_loader_force(boot), .key_cfg_bad(kbad), .temp_unprotect_en(en));

	// Clock and erase pulse counter
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) if (ers === 1'b1) erase_cnt++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Registered read, one cycle after index
	task automatic chk_rd(input logic [4:0] idx, input logic c, input logic [7:0] exp);
		opt_rindex = idx;
		opt_rcompl = c;
		@(posedge clk);
		#1;
		chk(opt_rdata, exp);
	endtask : chk_rd

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	// Scenarios
	task automatic t_keys();
		chk(en, 1'b1);
		chk(kbad, 1'b1);
		chk_rd(OPT_IDX_CTRL, 1'b1, OPT_COMPL_RESET);
		chk_rd(OPT_IDX_FAIL, 1'b1, OPT_RESET);
		u_prog.prog_keys(KEY_GOOD);
		for (int i = 0; i < KEY_COUNT; i++) u_prog.try_key(KEY_GOOD ^ (32'h1 << (8 * i)), 1);
		chk_rd(OPT_IDX_FAIL, 1'b0, 8'h04);
		chk(kbad, 1'b0);
		chk(unl, 1'b0);
		$display("keys test done");
	endtask : t_keys

	task automatic t_cnt_wr();
		u_prog.wr_opt(OPT_IDX_FAIL, 8'h02, 0);
		chk_rd(OPT_IDX_FAIL, 1'b0, 8'h04);
		u_prog.wr_opt(OPT_IDX_CTRL, 8'hF5, 1);
		chk(en, 1'b0);
		chk_rd(OPT_IDX_CTRL, 1'b1, 8'h0A);
		u_prog.wr_opt(OPT_IDX_FAIL, 8'h07, 0);
		u_prog.try_key(~KEY_GOOD, 1);
		u_prog.try_key(KEY_GOOD, 1);
		chk_rd(OPT_IDX_FAIL, 1'b0, 8'h07);
		chk(unl, 1'b0);
		u_prog.wr_opt(OPT_IDX_CTRL, 8'h00, 1);
		chk(en, 1'b1);
		$display("counter write test done");
	endtask : t_cnt_wr

	task automatic t_erase();
		int n;
		n = erase_cnt;
		u_prog.try_key(~KEY_GOOD, 3);
		chk(erase_cnt - n, 1);
		chk_rd(OPT_IDX_FAIL, 1'b0, FAIL_LIMIT);
		u_prog.try_key(KEY_GOOD, 2);
		chk(unl, 1'b0);
		chk(erase_cnt - n, 1);
		u_prog.wr_opt(OPT_IDX_CTRL, 8'h05, 1);
		u_prog.wr_opt(OPT_IDX_FAIL, 8'h00, 1);
		u_prog.wr_opt(OPT_IDX_CTRL, 8'h00, 1);
		u_prog.try_key(KEY_GOOD, 1);
		chk(unl, 1'b1);
		$display("erase test done");
	endtask : t_erase

	task automatic t_boot();
		u_prog.wr_opt(OPT_IDX_BOOT, BOOT_ON, 1);
		chk(boot, 1'b1);
		chk_rd(OPT_IDX_BOOT, 1'b1, BOOT_ON_COMPL);
		u_prog.wr_opt(OPT_IDX_BOOT, 8'h54, 1);
		chk(boot, 1'b0);
		$display("boot test done");
	endtask : t_boot

	// Main sequence
	initial begin
		arst_n     = 1'b0;
		opt_rindex = 5'h00;
		opt_rcompl = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		arst_n = 1'b1;
		@(posedge clk);
		#1;
		t_keys();
		t_cnt_wr();
		t_erase();
		t_boot();
		end_sim();
	end

	// Watchdog
	initial begin
		#50000;
		error_cnt++;
		end_sim();
	end
endmodule : testbench
